// [logic/trf_pkg.sv]
// Constants, types and helpers shared by the tape record formatter.
//
// Overview of operation
// - Nine-bit characters: eight data plus parity track
// - NRZI track toggles on one, holds on zero
// - NRZI cyclic check four spaces after data
// - NRZI longitudinal check four spaces after cyclic
// - Longitudinal check makes each track count even
// - NRZI file mark: 23 octal, seven blanks, check
// - NRZI file mark carries no cyclic check
// - Phase cell: one mid-cell transition per bit
// - Phase runs double transition rate, alternation single
// - Phase record: preamble, data, postamble in order
// - Preamble: forty zero chars then all ones
// - Postamble: all ones then forty zero chars
// - Reader syncs on zero run, ones starts data
// - Phase file mark: forty zeros, bits 0,5,1
// - Identification burst alternates on parity track only
// - Identification burst at tape start, 1.7 inch
// - Extended gap always precedes every file mark
// - Record gap erased, at least half inch
// - Extended gap three inches, also after tape start
package trf_pkg;

	// ----------------------------------------------------------------
	// Character layout
	// ----------------------------------------------------------------
	localparam int          TRK_W       = 9;
	localparam int          DATA_W      = 8;
	localparam int          PAR_BIT     = 8;
	localparam logic [8:0]  CH_ZERO     = 9'h000;
	localparam logic [8:0]  CH_ONES     = 9'h1ff;
	localparam logic [8:0]  MASK_ALL    = 9'h1ff;
	localparam logic [8:0]  MASK_NONE   = 9'h000;
	localparam logic [8:0]  MASK_PE_TM  = 9'h023;
	localparam logic [8:0]  MASK_IDB    = 9'h100;
	localparam logic [7:0]  MARK_CODE   = 8'h13;
	localparam logic [8:0]  CRC_POLY    = 9'h0f5;

	// ----------------------------------------------------------------
	// Format lengths in characters and tenths of an inch
	// ----------------------------------------------------------------
	localparam int          AMBLE_ZEROS = 40;
	localparam int          CHECK_SPACE = 4;
	localparam int          MARK_BLANKS = 7;
	localparam int          PE_TM_ZEROS = 40;
	localparam int          GAP_TENTHS  = 5;
	localparam int          EXT_TENTHS  = 30;
	localparam int          IDB_TENTHS  = 17;
	localparam int          RD_MIN_ZERO = 16;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_NS      = 25;
	localparam int          HALF_CELL_NS = 6944;
	localparam int          HALF_CYC    = HALF_CELL_NS / CLK_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_REC  = 2'h0,
		CMD_MARK = 2'h1,
		CMD_BOT  = 2'h2
	} trf_cmd_t;

	typedef enum logic [4:0] {
		S_IDLE   = 5'h00,
		S_GAP    = 5'h01,
		S_IDB    = 5'h02,
		S_PRE_Z  = 5'h03,
		S_PRE_O  = 5'h04,
		S_DATA   = 5'h05,
		S_POST_O = 5'h06,
		S_POST_Z = 5'h07,
		S_PAD1   = 5'h08,
		S_CRC    = 5'h09,
		S_PAD2   = 5'h0a,
		S_LRC    = 5'h0b,
		S_TM_CH  = 5'h0c,
		S_TM_BLK = 5'h0d,
		S_TM_LRC = 5'h0e,
		S_PE_TM  = 5'h0f
	} trf_state_t;

	typedef enum logic [1:0] {
		R_HUNT = 2'h0,
		R_ARM  = 2'h1,
		R_DATA = 2'h2
	} trf_rd_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] with_par(input logic [7:0] d);
		return {~^d, d};
	endfunction : with_par

	function automatic logic [8:0] crc_step(input logic [8:0] c, input logic [8:0] d);
		logic [8:0] x;
		x = c ^ d;
		return x[8] ? ({x[7:0], 1'b0} ^ CRC_POLY) : {x[7:0], 1'b0};
	endfunction : crc_step

	function automatic logic [15:0] len_chars(input int tenths, input int cpi);
		int n;
		n = (tenths * cpi + 9) / 10;
		return n[15:0];
	endfunction : len_chars

endpackage : trf_pkg

// [logic/trf_fifo.sv]
// Character FIFO between the controller stream and the formatter.
`timescale 1ns/1ps
module trf_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         nrst_i,
	// Fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// Drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	import trf_pkg::*;

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} trf_fifo_st_t;

	trf_fifo_st_t q, d;
	logic push, pop;

	assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o  = q.mem[q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data_i;
			d.wp        = q.wp + 1'b1;
		end
		if (pop)
			d.rp = q.rp + 1'b1;
		if (push && !pop)
			d.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			d.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	a_fifo_full: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(q.cnt == (AW+1)'(DEPTH)) |-> !in_ready_o && out_valid_o)
		else $error("FIFO full without back-pressure");

endmodule : trf_fifo

// [logic/trf_line_enc.sv]
// Per-track write level encoder for NRZI and phase recording.
`timescale 1ns/1ps
module trf_line_enc (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	// Character timing
	input  wire logic       pe_i,
	input  wire logic       char_en_i,
	input  wire logic       mid_en_i,
	input  wire logic [8:0] chr_i,
	// Track levels
	output logic [8:0]      trk_o
);
	import trf_pkg::*;

	typedef struct packed {
		logic [8:0] lvl;
	} trf_enc_st_t;

	trf_enc_st_t q, d;

	assign trk_o = q.lvl;

	always_comb begin
		d = q;
		if (char_en_i)
			d.lvl = pe_i ? chr_i : (q.lvl ^ chr_i);
		else if (pe_i && mid_en_i)
			d.lvl = ~q.lvl;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	a_nrzi_toggle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(!pe_i && char_en_i) |=> trk_o == ($past(trk_o) ^ $past(chr_i)))
		else $error("NRZI level did not follow the ones");
	a_pe_first_half: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(pe_i && char_en_i) |=> trk_o == $past(chr_i))
		else $error("Phase cell first half wrong");
	a_pe_mid_cell: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(pe_i && !char_en_i && mid_en_i) |=> trk_o == ~$past(trk_o))
		else $error("Phase cell missing mid transition");

endmodule : trf_line_enc

// [logic/trf_formatter.sv]
// Tape record formatter: write sequencer, check characters and read sync.
`timescale 1ns/1ps
module trf_formatter #(
	parameter int DENSITY_NRZ = 800,
	parameter int DENSITY_PE  = 1600,
	parameter int FIFO_DEPTH  = 32
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	// Command port
	input  wire logic              cmd_valid_i,
	input  wire trf_pkg::trf_cmd_t cmd_code_i,
	input  wire logic              mode_pe_i,
	output logic                   cmd_ready_o,
	output logic                   underrun_o,
	// Character stream in
	input  wire logic              wr_valid_i,
	input  wire logic [7:0]        wr_data_i,
	input  wire logic              wr_last_i,
	output logic                   wr_ready_o,
	// Transport write channel
	input  wire logic              char_clk_i,
	output logic [8:0]             trk_o,
	output logic [8:0]             trk_wen_o,
	output logic                   wr_gate_o,
	// Transport read channel
	input  wire logic              rd_stb_i,
	input  wire logic [8:0]        rd_data_i,
	input  wire logic              rd_end_i,
	output logic [7:0]             rd_char_o,
	output logic                   rd_par_o,
	output logic                   rd_valid_o,
	output logic                   rd_sync_o
);
	import trf_pkg::*;

	// ----------------------------------------------------------------
	// Derived lengths
	// ----------------------------------------------------------------
	localparam logic [15:0] GAP_NRZ = len_chars(GAP_TENTHS, DENSITY_NRZ);
	localparam logic [15:0] GAP_PE  = len_chars(GAP_TENTHS, DENSITY_PE);
	localparam logic [15:0] EXT_NRZ = len_chars(EXT_TENTHS, DENSITY_NRZ);
	localparam logic [15:0] EXT_PE  = len_chars(EXT_TENTHS, DENSITY_PE);
	localparam logic [15:0] IDB_LEN = len_chars(IDB_TENTHS, DENSITY_PE);
	localparam logic [15:0] AMB_LAST = 16'(AMBLE_ZEROS - 1);
	localparam logic [15:0] CHK_LAST = 16'(CHECK_SPACE - 2);
	localparam logic [15:0] BLK_LAST = 16'(MARK_BLANKS - 1);
	localparam logic [15:0] PTM_LAST = 16'(PE_TM_ZEROS - 1);
	localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

	if (DENSITY_NRZ < 10 || DENSITY_PE < 10 || FIFO_DEPTH < 2) begin : g_bad_param
		$error("Density or FIFO depth out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  ck_s;
		logic [2:0]  rs_s;
		logic [1:0]  re_s;
		logic [8:0]  rd1;
		logic [8:0]  rd2;
		trf_state_t  st;
		logic [15:0] cnt;
		logic        pe;
		trf_cmd_t    op;
		logic [8:0]  lrc;
		logic [8:0]  crc;
		logic        gate;
		logic [8:0]  wen;
		logic [15:0] half;
		logic        half_run;
		logic        underrun;
		trf_rd_t     rd_st;
		logic [7:0]  rd_zc;
		logic [8:0]  rd_chr;
		logic        rd_vld;
	} trf_fmt_st_t;

	trf_fmt_st_t q, d;

	logic        char_en;
	logic        mid_en;
	logic        rd_en;
	logic [8:0]  chr_out;
	logic        fifo_valid;
	logic [8:0]  fifo_data;
	logic        fifo_pop;

	// ----------------------------------------------------------------
	// Buffer and encoder
	// ----------------------------------------------------------------
	trf_fifo #(
		.W     (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (wr_valid_i),
		.in_data_i   ({wr_last_i, wr_data_i}),
		.in_ready_o  (wr_ready_o),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (fifo_pop)
	);

	trf_line_enc u_enc (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.pe_i       (q.pe),
		.char_en_i  (char_en),
		.mid_en_i   (mid_en),
		.chr_i      (chr_out),
		.trk_o      (trk_o)
	);

	// ----------------------------------------------------------------
	// Strobes and outputs
	// ----------------------------------------------------------------
	assign char_en     = q.ck_s[1] && !q.ck_s[2];
	assign rd_en       = q.rs_s[1] && !q.rs_s[2];
	assign mid_en      = q.half_run && (q.half == HALF_LAST);
	assign fifo_pop    = char_en && (q.st == S_DATA) && fifo_valid;
	assign cmd_ready_o = (q.st == S_IDLE);
	assign underrun_o  = q.underrun;
	assign wr_gate_o   = q.gate;
	assign trk_wen_o   = q.wen;
	assign rd_char_o   = q.rd_chr[7:0];
	assign rd_par_o    = q.rd_chr[PAR_BIT];
	assign rd_valid_o  = q.rd_vld;
	assign rd_sync_o   = (q.rd_st == R_DATA);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [8:0] chr;
		logic       gate;
		logic [8:0] wen;
		chr  = CH_ZERO;
		gate = 1'b1;
		wen  = MASK_ALL;
		d    = q;

		d.ck_s = {q.ck_s[1:0], char_clk_i};
		d.rs_s = {q.rs_s[1:0], rd_stb_i};
		d.re_s = {q.re_s[0], rd_end_i};
		d.rd1  = rd_data_i;
		d.rd2  = q.rd1;
		d.rd_vld = 1'b0;

		// Mid-cell divider restarts on every character
		if (char_en) begin
			d.half     = '0;
			d.half_run = 1'b1;
		end else if (q.half_run) begin
			d.half     = q.half + 16'h0001;
			d.half_run = (q.half != HALF_LAST);
		end

		if (q.st == S_IDLE && cmd_valid_i) begin
			d.pe = mode_pe_i;
			d.op = cmd_code_i;
			if (cmd_code_i == CMD_REC)
				d.underrun = 1'b0;
			if (cmd_code_i == CMD_BOT && mode_pe_i) begin
				d.st  = S_IDB;
				d.cnt = IDB_LEN - 16'h0001;
			end else begin
				d.st  = S_GAP;
				d.cnt = (cmd_code_i == CMD_REC) ?
					((mode_pe_i ? GAP_PE : GAP_NRZ) - 16'h0001) :
					((mode_pe_i ? EXT_PE : EXT_NRZ) - 16'h0001);
			end
		end

		if (char_en) begin
			// Idle keeps a count just loaded by an accepted command
			if (q.st != S_IDLE)
				d.cnt = q.cnt - 16'h0001;
			case (q.st)
				S_IDLE: begin
					gate = 1'b0;
					wen  = MASK_NONE;
				end
				S_GAP: begin
					gate = 1'b0;
					wen  = MASK_NONE;
					if (q.cnt == 16'h0000) begin
						d.lrc = '0;
						d.crc = '0;
						if (q.op == CMD_BOT)
							d.st = S_IDLE;
						else if (q.op == CMD_REC) begin
							d.st  = q.pe ? S_PRE_Z : S_DATA;
							d.cnt = AMB_LAST;
						end else begin
							d.st  = q.pe ? S_PE_TM : S_TM_CH;
							d.cnt = PTM_LAST;
						end
					end
				end
				S_IDB: begin
					chr = {q.cnt[0], 8'h00};
					wen = MASK_IDB;
					if (q.cnt == 16'h0000) begin
						d.st  = S_GAP;
						d.cnt = EXT_PE - 16'h0001;
					end
				end
				S_PRE_Z: begin
					chr = CH_ZERO;
					if (q.cnt == 16'h0000)
						d.st = S_PRE_O;
				end
				S_PRE_O: begin
					chr  = CH_ONES;
					d.st = S_DATA;
				end
				S_DATA: begin
					if (fifo_valid) begin
						chr   = with_par(fifo_data[7:0]);
						d.lrc = q.lrc ^ chr;
						d.crc = crc_step(q.crc, chr);
					end else begin
						gate       = 1'b0;
						wen        = MASK_NONE;
						d.underrun = 1'b1;
					end
					if (!fifo_valid || fifo_data[8]) begin
						d.st  = q.pe ? S_POST_O : S_PAD1;
						d.cnt = CHK_LAST;
					end
				end
				S_POST_O: begin
					chr   = CH_ONES;
					d.st  = S_POST_Z;
					d.cnt = AMB_LAST;
				end
				S_POST_Z: begin
					chr = CH_ZERO;
					if (q.cnt == 16'h0000)
						d.st = S_IDLE;
				end
				S_PAD1: begin
					if (q.cnt == 16'h0000)
						d.st = S_CRC;
				end
				S_CRC: begin
					chr   = q.crc;
					d.st  = S_PAD2;
					d.cnt = CHK_LAST;
				end
				S_PAD2: begin
					if (q.cnt == 16'h0000)
						d.st = S_LRC;
				end
				S_LRC: begin
					chr  = q.lrc;
					d.st = S_IDLE;
				end
				S_TM_CH: begin
					chr   = with_par(MARK_CODE);
					d.lrc = with_par(MARK_CODE);
					d.st  = S_TM_BLK;
					d.cnt = BLK_LAST;
				end
				S_TM_BLK: begin
					if (q.cnt == 16'h0000)
						d.st = S_TM_LRC;
				end
				S_TM_LRC: begin
					chr  = q.lrc;
					d.st = S_IDLE;
				end
				S_PE_TM: begin
					chr = CH_ZERO;
					wen = MASK_PE_TM;
					if (q.cnt == 16'h0000)
						d.st = S_IDLE;
				end
				default: begin
					gate = 1'b0;
					wen  = MASK_NONE;
					d.st = S_IDLE;
				end
			endcase
			d.gate = gate;
			d.wen  = wen;
		end

		// Read side: phase mode hunts zero run, ones character opens data; NRZI goes straight to data
		if (q.re_s[1])
			d.rd_st = R_HUNT;
		else if (rd_en) begin
			case (q.rd_st)
				R_HUNT: begin
					if (!mode_pe_i)
						d.rd_st = R_DATA;
					else if (q.rd2 == CH_ZERO) begin
						d.rd_zc = (q.rd_zc == 8'hff) ? q.rd_zc : q.rd_zc + 8'h01;
						if (q.rd_zc >= 8'(RD_MIN_ZERO - 1))
							d.rd_st = R_ARM;
					end else
						d.rd_zc = '0;
				end
				R_ARM: begin
					d.rd_zc = '0;
					if (q.rd2 == CH_ONES)
						d.rd_st = R_DATA;
					else if (q.rd2 != CH_ZERO)
						d.rd_st = R_HUNT;
				end
				R_DATA: begin
					d.rd_chr = q.rd2;
					d.rd_vld = 1'b1;
				end
				default: d.rd_st = R_HUNT;
			endcase
			if (q.rd_st == R_HUNT && !mode_pe_i) begin
				d.rd_chr = q.rd2;
				d.rd_vld = 1'b1;
			end
		end
		chr_out = chr;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_last_data;
		(q.st == S_DATA) && char_en && fifo_valid && fifo_data[8] && !q.pe;
	endsequence
	sequence s_pad_done;
		(q.st == S_PAD1) && char_en && (q.cnt == 16'h0000);
	endsequence

	a_crc_spacing: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		s_last_data |=> (q.st == S_PAD1) && (q.cnt == CHK_LAST))
		else $error("Cyclic check not four spaces after data");
	a_crc_follows: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		s_pad_done |=> (q.st == S_CRC))
		else $error("Cyclic check not written after padding");
	a_lrc_spacing: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_CRC) && char_en) |=> (q.st == S_PAD2) && (q.cnt == CHK_LAST))
		else $error("Longitudinal check spacing wrong");
	a_pre_length: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_PRE_Z) && char_en) |-> (q.cnt <= AMB_LAST) && (chr_out == CH_ZERO))
		else $error("Preamble zero run wrong");
	a_post_ones: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_POST_O) && char_en) |-> chr_out == CH_ONES ##1 q.st == S_POST_Z)
		else $error("Postamble ones character wrong");
	a_mark_no_crc: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_GAP) && char_en && (q.cnt == 16'h0000) && (q.op == CMD_MARK) && !q.pe)
		|=> (q.st == S_TM_CH))
		else $error("Cyclic check inside file mark");
	a_gap_erased: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_GAP) && char_en) |=> !wr_gate_o && (trk_wen_o == MASK_NONE))
		else $error("Record gap not erased");
	a_idb_track: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_IDB) && char_en) |=> (trk_wen_o == MASK_IDB))
		else $error("Identification burst on wrong tracks");
	a_lrc_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		((q.st == S_GAP) && char_en && (q.cnt == 16'h0000)) |=> (q.lrc == '0))
		else $error("Longitudinal accumulator not cleared");

endmodule : trf_formatter

// [bench/trf_tape_model.sv]
// Tape transport model: character clock and write-head capture.
`timescale 1ns/1ps
module trf_tape_model (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// Bench control
	input  wire logic        run_i,
	input  wire logic [15:0] period_i,
	// Write channel
	output logic             char_clk_o,
	input  wire logic [8:0]  trk_i,
	input  wire logic [8:0]  trk_wen_i,
	input  wire logic        wr_gate_i
);
	logic [15:0] cnt;
	logic [8:0]  h1;
	logic [8:0]  half_q [$];
	logic [18:0] cap_q  [$];

	// ----------------------------------------------------------------
	// Clock stands still outside frames
	// ----------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (!nrst_i || !run_i) begin
			cnt <= 16'h0000;
			char_clk_o <= 1'b0;
		end else begin
			cnt <= (cnt == period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			char_clk_o <= (cnt < period_i / 2);
			if (cnt == period_i / 4)
				h1 <= trk_i;
			// End of space: second half in phase mode
			if (cnt == period_i - 16'h0002) begin
				half_q.push_back(h1);
				cap_q.push_back({wr_gate_i, trk_wen_i, trk_i});
			end
		end
	end
endmodule : trf_tape_model

// [bench/tape_record_formatter_tb.sv]
// Self-checking bench for the tape record formatter.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin failures++; \
	$display("wrong value %s exp %h seen %h", nm, e, s); end end
module tape_record_formatter_tb;
	import trf_pkg::*;
	localparam int GAP    = 10;
	localparam int EXT    = 60;
	localparam int GAP_PE = 5;
	localparam int PHASE_ID_BURST    = 17;
	localparam int LIMIT  = 90000;
	logic        core_clk_i, nrst_i, cmd_valid_i, mode_pe_i, cmd_ready_o, underrun_o;
	trf_cmd_t    cmd_code_i;
	logic        wr_valid_i, wr_last_i, wr_ready_o, char_clk_i, wr_gate_o;
	logic [7:0]  wr_data_i, rd_char_o;
	logic [8:0]  trk_o, trk_wen_o, rd_data_i, lrc, c;
	logic        rd_stb_i, rd_end_i, rd_par_o, rd_valid_o, rd_sync_o, run, v;
	logic [15:0] period;
	int          failures, n_compared, cyc, gap_n;
	int          exp_q [$];
	logic [8:0]  got_q [$];
	logic [7:0]  dat [$];

	trf_formatter #(.DENSITY_NRZ(20), .DENSITY_PE(10)) DUT (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .mode_pe_i(mode_pe_i), .cmd_ready_o(cmd_ready_o),
		.underrun_o(underrun_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
		.wr_last_i(wr_last_i), .wr_ready_o(wr_ready_o), .char_clk_i(char_clk_i),
		.trk_o(trk_o), .trk_wen_o(trk_wen_o), .wr_gate_o(wr_gate_o),
		.rd_stb_i(rd_stb_i), .rd_data_i(rd_data_i), .rd_end_i(rd_end_i),
		.rd_char_o(rd_char_o), .rd_par_o(rd_par_o), .rd_valid_o(rd_valid_o),
		.rd_sync_o(rd_sync_o));

	trf_tape_model P (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .run_i(run),
		.period_i(period), .char_clk_o(char_clk_i), .trk_i(trk_o),
		.trk_wen_i(trk_wen_o), .wr_gate_i(wr_gate_o));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] pw(input logic [7:0] d);
		return {~^d, d};
	endfunction : pw

	task close_out();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task push(input logic [7:0] d, input logic l);
		@(negedge core_clk_i);
		`CHK("wr_ready", 1'b1, wr_ready_o)
		wr_valid_i = 1'b1;
		wr_data_i = d;
		wr_last_i = l;
		@(posedge core_clk_i);
	endtask : push

	task run_cmd(input trf_cmd_t k, input logic pe, input int per);
		int n;
		P.cap_q.delete();
		P.half_q.delete();
		@(negedge core_clk_i);
		period = per[15:0];
		cmd_code_i = k;
		mode_pe_i = pe;
		cmd_valid_i = 1'b1;
		@(negedge core_clk_i);
		cmd_valid_i = 1'b0;
		run = 1'b1;
		`CHK("cmd_ready", 1'b0, cmd_ready_o)
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 80000) begin
			@(negedge core_clk_i);
			n++;
		end
		`CHK("cmd done", 1'b1, cmd_ready_o)
		repeat (4 * per) @(negedge core_clk_i);
		run = 1'b0;
	endtask : run_cmd

	// Decode spaces from the first written one on
	task decode(input logic pe, input logic [8:0] m = 9'h1ff);
		logic [8:0] prev;
		int i;
		got_q.delete();
		gap_n = 0;
		while (gap_n < P.cap_q.size() && P.cap_q[gap_n][18] !== 1'b1)
			gap_n++;
		prev = (gap_n > 0) ? P.cap_q[gap_n - 1][8:0] : 9'h000;
		for (i = gap_n; i < P.cap_q.size(); i++) begin
			if (pe && P.cap_q[i][18] === 1'b1) begin
				got_q.push_back(P.half_q[i]);
				`CHK("pe cell", ~P.half_q[i], P.cap_q[i][8:0])
				`CHK("pe wen", m, P.cap_q[i][17:9])
			end
			if (!pe)
				got_q.push_back(P.cap_q[i][8:0] ^ prev);
			prev = P.cap_q[i][8:0];
		end
	endtask : decode

	task rd_send(input logic [8:0] d);
		@(negedge core_clk_i);
		rd_data_i = d;
		rd_stb_i = 1'b1;
		v = 1'b0;
		repeat (6) @(negedge core_clk_i) if (rd_valid_o === 1'b1) v = 1'b1;
		rd_stb_i = 1'b0;
		repeat (6) @(negedge core_clk_i) if (rd_valid_o === 1'b1) v = 1'b1;
	endtask : rd_send

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{nrst_i, cmd_valid_i, mode_pe_i, wr_valid_i, wr_last_i, run} = '0;
		{rd_stb_i, rd_end_i, failures, n_compared, cyc} = '0;
		wr_data_i = 8'h00;
		rd_data_i = 9'h000;
		cmd_code_i = CMD_REC;
		period = 16'h0014;
		void'($urandom(48741));
		repeat (20) @(posedge core_clk_i);
		@(negedge core_clk_i);
		nrst_i = 1'b1;
		run_cmd(CMD_REC, 1'b0, 20);
		`CHK("underrun", 1'b1, underrun_o)
		$display("test underrun done");
		lrc = 9'h000;
		for (int i = 0; i < 32; i++) begin
			dat.push_back(8'($urandom));
			push(dat[i], i == 31);
		end
		@(negedge core_clk_i);
		wr_valid_i = 1'b0;
		wr_last_i = 1'b0;
		`CHK("wr_ready full", 1'b0, wr_ready_o)
		run_cmd(CMD_REC, 1'b0, 20);
		`CHK("underrun clear", 1'b0, underrun_o)
		decode(1'b0);
		`CHK("gap", 1'b1, gap_n >= GAP)
		exp_q.delete();
		foreach (dat[i]) begin
			exp_q.push_back(pw(dat[i]));
			lrc ^= pw(dat[i]);
		end
		exp_q = {exp_q, 0, 0, 0, -1, 0, 0, 0, int'(lrc)};
		foreach (exp_q[i]) if (exp_q[i] >= 0) `CHK("nrzi", exp_q[i][8:0], got_q[i])
		$display("test nrzi record done");
		run_cmd(CMD_MARK, 1'b0, 20);
		decode(1'b0);
		`CHK("mark gap", 1'b1, gap_n >= EXT)
		exp_q = {'h013, 0, 0, 0, 0, 0, 0, 0, 'h013, 0, 0};
		foreach (exp_q[i]) `CHK("mark", exp_q[i][8:0], got_q[i])
		$display("test nrzi mark done");
		run_cmd(CMD_BOT, 1'b0, 20);
		decode(1'b0);
		`CHK("bot gap", 1'b1, gap_n >= EXT && got_q.size() == 0)
		$display("test nrzi start done");
		dat.delete();
		for (int i = 0; i < 3; i++) begin
			dat.push_back(8'($urandom));
			push(dat[i], i == 2);
		end
		@(negedge core_clk_i);
		wr_valid_i = 1'b0;
		run_cmd(CMD_REC, 1'b1, 300);
		decode(1'b1);
		`CHK("pe gap", 1'b1, gap_n >= GAP_PE)
		exp_q.delete();
		repeat (40) exp_q.push_back(0);
		exp_q.push_back('h1ff);
		foreach (dat[i]) exp_q.push_back(pw(dat[i]));
		exp_q.push_back('h1ff);
		repeat (40) exp_q.push_back(0);
		`CHK("pe length", 85, got_q.size())
		foreach (exp_q[i]) `CHK("pe", exp_q[i][8:0], got_q[i])
		$display("test pe record done");
		run_cmd(CMD_MARK, 1'b1, 300);
		decode(1'b1, 9'h023);
		`CHK("pe mark gap", 1'b1, gap_n >= EXT / 2)
		`CHK("pe mark length", 40, got_q.size())
		foreach (got_q[i]) `CHK("pe mark", 9'h000, got_q[i])
		$display("test pe mark done");
		run_cmd(CMD_BOT, 1'b1, 300);
		decode(1'b1, 9'h100);
		`CHK("idb at start", 0, gap_n)
		`CHK("idb length", 1'b1, got_q.size() >= PHASE_ID_BURST)
		for (int i = 1; i < got_q.size(); i++) `CHK("idb", {~got_q[i-1][8], 8'h00}, got_q[i])
		`CHK("idb gap", 1'b1, P.cap_q.size() - got_q.size() >= EXT / 2)
		$display("test pe start done");
		mode_pe_i = 1'b1;
		rd_send(9'h1ff);
		`CHK("hunt", 1'b0, v)
		repeat (16) rd_send(9'h000);
		rd_send(9'h1ff);
		`CHK("sync", 1'b1, rd_sync_o)
		c = 9'($urandom);
		rd_send(c);
		`CHK("rd valid", 1'b1, v)
		`CHK("rd char", c, {rd_par_o, rd_char_o})
		rd_end_i = 1'b1;
		repeat (8) @(negedge core_clk_i);
		`CHK("sync end", 1'b0, rd_sync_o)
		rd_end_i = 1'b0;
		mode_pe_i = 1'b0;
		c = 9'($urandom);
		rd_send(c);
		`CHK("nrzi rd", {1'b1, c}, {v, rd_par_o, rd_char_o})
		$display("test read done");
		close_out();
	end
endmodule : tape_record_formatter_tb
